// file: hw/pse_encoder.v
// Functional notes
// - Letter is T unmuted/unlocked, L locked, M muted, U muted and locked.
// - First status byte is reserved and always reported as zero.
// - Second byte bits 7-6 embedded audio, bits 5-4 encryption status.
// - Second byte bits 3-2 signal present, bits 1-0 connection status.
// - Field codes: 00 unknown, 01 reserved, 10 absent, 11 present.
// - Each byte goes out as two uppercase hex characters after the letter.
//
// Added by the designer: the address map and register access over AXI4-Lite.
`include "pse_consts.vh"

module pse_encoder (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        nrst_i,
  // Port condition pins
  input  wire        mute_i,
  input  wire        lock_i,
  input  wire [1:0]  audio_i,
  input  wire [1:0]  encr_i,
  input  wire [1:0]  signal_i,
  input  wire [1:0]  conn_i,
  // Character stream
  input  wire        query_i,
  output reg  [7:0]  char_o,
  output reg         char_valid_o,
  output reg         char_last_o,
  output reg  [39:0] code_o,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Interrupt
  output reg         irq_o
);

  localparam ST_IDLE = 2'b01;
  localparam ST_SEND = 2'b10;

  // Held as a sized constant so each nibble is cut out on purpose
  localparam [7:0] RSVD_BYTE = `PSE_RSVD_BYTE;

  function [7:0] hex_chr;
    input [3:0] nib;
    begin
      if (nib < 4'hA) begin
        hex_chr = `PSE_CHR_ZERO + {4'h0, nib};
      end else begin
        hex_chr = `PSE_CHR_A_OFS + {4'h0, nib};
      end
    end
  endfunction

  // Pin synchroniser: stage 1 feeds stage 2 only
  reg  [9:0]  s1_reg;
  reg  [9:0]  s2_reg;
  reg  [9:0]  s3_reg;
  reg  [9:0]  pins_reg;
  wire [9:0]  pins_raw = {lock_i, mute_i, audio_i, encr_i, signal_i, conn_i};
  wire [9:0]  pins_agree = ~(s2_reg ^ s3_reg);

  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      s1_reg   <= 10'h000;
      s2_reg   <= 10'h000;
      s3_reg   <= 10'h000;
      pins_reg <= 10'h000;
    end else begin
      s1_reg   <= pins_raw;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      // A bit changes only once stages 2 and 3 agree
      pins_reg <= (s2_reg & pins_agree) | (pins_reg & ~pins_agree);
    end
  end

  // Software registers
  reg  [31:0] ctrl_reg;
  reg  [31:0] ovr_reg;
  reg  [1:0]  irq_stat_reg;
  reg  [1:0]  irq_mask_reg;

  // Either the pins or the override word supply the flags
  wire [9:0]  src_flags = ctrl_reg[0] ? ovr_reg[9:0] : pins_reg;
  wire        mute_f    = src_flags[`PSE_BIT_MUTE];
  wire        lock_f    = src_flags[`PSE_BIT_LOCK];

  // Reserved field code is folded to unknown
  wire [7:0]  stat_byte;
  wire [3:0]  rsvd_seen;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_fld
      assign rsvd_seen[g] = (src_flags[2*g+1:2*g] == `PSE_CODE_RSVD);
      assign stat_byte[2*g+1:2*g] = rsvd_seen[g] ? `PSE_CODE_UNKNOWN : src_flags[2*g+1:2*g];
    end
  endgenerate

  reg  [7:0]  letter;
  always @* begin
    case ({mute_f, lock_f})
      2'b00:   letter = `PSE_CHR_T;
      2'b01:   letter = `PSE_CHR_L;
      2'b10:   letter = `PSE_CHR_M;
      default: letter = `PSE_CHR_U;
    endcase
  end

  // Bits 7-4 hold audio and encryption, bits 3-0 signal and connection
  wire [39:0] code_next = {letter,
                           hex_chr(RSVD_BYTE[7:4]), hex_chr(RSVD_BYTE[3:0]),
                           hex_chr(stat_byte[7:4]),
                           hex_chr(stat_byte[3:0])};

  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      code_o <= `PSE_RST_CODE;
    end else begin
      code_o <= code_next;
    end
  end

  wire ev_change = (code_next != code_o);
  wire ev_rsvd   = |rsvd_seen;

  // Character stream; snapshot taken at the query so all five chars agree
  reg  [1:0]  st_reg;
  reg  [39:0] shift_reg;
  reg  [2:0]  left_reg;

  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      st_reg       <= ST_IDLE;
      shift_reg    <= 40'h0000000000;
      left_reg     <= 3'h0;
      char_o       <= 8'h00;
      char_valid_o <= 1'b0;
      char_last_o  <= 1'b0;
    end else begin
      char_valid_o <= 1'b0;
      char_last_o  <= 1'b0;
      case (st_reg)
        ST_IDLE: begin
          if (query_i) begin
            shift_reg <= code_o;
            left_reg  <= `PSE_NUM_CHARS;
            st_reg    <= ST_SEND;
          end
        end
        ST_SEND: begin
          char_o       <= shift_reg[39:32];
          char_valid_o <= 1'b1;
          char_last_o  <= (left_reg == 3'h1);
          shift_reg    <= {shift_reg[31:0], 8'h00};
          left_reg     <= left_reg - 3'h1;
          if (left_reg == 3'h1) begin
            st_reg <= ST_IDLE;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // AXI4-Lite write path: address and data captured in either order
  reg         aw_held_reg;
  reg         w_held_reg;
  reg  [7:0]  awaddr_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  wire        wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire [31:0] strb_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire        wr_ok = (awaddr_reg == `PSE_ADDR_CTRL) || (awaddr_reg == `PSE_ADDR_OVR) ||
                      (awaddr_reg == `PSE_ADDR_STATUS) || (awaddr_reg == `PSE_ADDR_CODE_LO) ||
                      (awaddr_reg == `PSE_ADDR_CODE_HI) || (awaddr_reg == `PSE_ADDR_IRQ_STAT) ||
                      (awaddr_reg == `PSE_ADDR_IRQ_MASK);
  wire [1:0]  irq_clr = (wr_go && awaddr_reg == `PSE_ADDR_IRQ_STAT && wstrb_reg[0]) ? wdata_reg[1:0] : 2'h0;

  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PSE_RESP_OKAY;
      ctrl_reg      <= `PSE_RST_CTRL;
      ovr_reg       <= `PSE_RST_OVR;
      irq_mask_reg  <= `PSE_RST_MASK;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `PSE_RESP_OKAY : `PSE_RESP_DECERR;
        case (awaddr_reg)
          `PSE_ADDR_CTRL:     ctrl_reg <= {31'h0, (wdata_reg[0] & strb_mask[0]) | (ctrl_reg[0] & ~strb_mask[0])};
          `PSE_ADDR_OVR:      ovr_reg  <= {22'h0, (wdata_reg[9:0] & strb_mask[9:0]) | (ovr_reg[9:0] & ~strb_mask[9:0])};
          `PSE_ADDR_IRQ_MASK: if (wstrb_reg[0]) irq_mask_reg <= wdata_reg[1:0];
          default:            ctrl_reg <= ctrl_reg;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Interrupt status: a new event wins over a same-cycle clear
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      irq_stat_reg <= 2'h0;
      irq_o        <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | {ev_rsvd, ev_change};
      irq_o        <= |(((irq_stat_reg & ~irq_clr) | {ev_rsvd, ev_change}) & irq_mask_reg);
    end
  end

  // AXI4-Lite read path
  reg  [31:0] rd_word;
  reg         rd_hit;
  always @* begin
    rd_hit  = 1'b1;
    rd_word = 32'h00000000;
    case ({s_axi_araddr[7:2], 2'b00})
      `PSE_ADDR_CTRL:     rd_word = ctrl_reg;
      `PSE_ADDR_OVR:      rd_word = ovr_reg;
      `PSE_ADDR_STATUS:   rd_word = {22'h0, lock_f, mute_f, stat_byte};
      `PSE_ADDR_CODE_LO:  rd_word = {code_o[15:8], code_o[23:16], code_o[31:24], code_o[39:32]};
      `PSE_ADDR_CODE_HI:  rd_word = {24'h0, code_o[7:0]};
      `PSE_ADDR_IRQ_STAT: rd_word = {30'h0, irq_stat_reg};
      `PSE_ADDR_IRQ_MASK: rd_word = {30'h0, irq_mask_reg};
      default:            rd_hit  = 1'b0;
    endcase
  end

  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PSE_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? `PSE_RESP_OKAY : `PSE_RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// file: hw/pse_consts.vh
`ifndef PSE_CONSTS_VH
`define PSE_CONSTS_VH

// Register byte addresses
`define PSE_ADDR_CTRL      8'h00
`define PSE_ADDR_OVR       8'h04
`define PSE_ADDR_STATUS    8'h08
`define PSE_ADDR_CODE_LO   8'h0C
`define PSE_ADDR_CODE_HI   8'h10
`define PSE_ADDR_IRQ_STAT  8'h14
`define PSE_ADDR_IRQ_MASK  8'h18

// Status byte field positions (low bit of each 2-bit field)
`define PSE_FLD_AUDIO      6
`define PSE_FLD_ENCR       4
`define PSE_FLD_SIGNAL     2
`define PSE_FLD_CONN       0

// Word layout of the flag view (OVR and STATUS)
`define PSE_BIT_MUTE       8
`define PSE_BIT_LOCK       9

// Field codes
`define PSE_CODE_UNKNOWN   2'h0
`define PSE_CODE_RSVD      2'h1
`define PSE_CODE_ABSENT    2'h2
`define PSE_CODE_PRESENT   2'h3

// Letters and characters
`define PSE_CHR_T          8'h54
`define PSE_CHR_L          8'h4C
`define PSE_CHR_M          8'h4D
`define PSE_CHR_U          8'h55
`define PSE_CHR_ZERO       8'h30
`define PSE_CHR_A_OFS      8'h37
`define PSE_RSVD_BYTE      8'h00

// Interrupt bits
`define PSE_IRQ_CHANGE     0
`define PSE_IRQ_RSVD       1

// Reset values
`define PSE_RST_CTRL       32'h00000000
`define PSE_RST_OVR        32'h00000000
`define PSE_RST_MASK       2'h0
`define PSE_RST_CODE       40'h5430303030

// Characters per status code
`define PSE_NUM_CHARS      3'h5

// Bus responses
`define PSE_RESP_OKAY      2'h0
`define PSE_RESP_DECERR    2'h3

`endif

// file: bench/pse_check_monitor.sv
module pse_chk (
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  // Character stream and code
  input wire logic [7:0]  char_o,
  input wire logic        char_valid_o,
  input wire logic        char_last_o,
  input wire logic [39:0] code_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Nibble characters that only 00, 10 and 11 fields can build
  function automatic logic fld_chr(input logic [7:0] c);
    return c inside {8'h30, 8'h32, 8'h33, 8'h38, 8'h41, 8'h42, 8'h43, 8'h45, 8'h46};
  endfunction
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence two_zeros;
    char_o == 8'h30 ##1 char_o == 8'h30;
  endsequence
  sequence five_chars;
    char_valid_o [*4] ##1 (char_valid_o && char_last_o);
  endsequence
  a_letter_legal: assert property (code_o[39:32] inside {8'h54, 8'h4C, 8'h4D, 8'h55})
    else $error("code letter out of set");
  a_rsvd_zero: assert property (code_o[31:16] == 16'h3030)
    else $error("reserved byte not zero");
  // Only nibbles built from 00, 10 and 11 fields may appear
  a_audio_char: assert property (fld_chr(code_o[15:8]))
    else $error("fourth char illegal");
  a_conn_char: assert property (fld_chr(code_o[7:0]))
    else $error("fifth char illegal");
  a_no_rsvd_code: assert property (char_last_o |-> fld_chr(char_o))
    else $error("streamed field carries 01");
  a_fourth_legal: assert property ($rose(char_valid_o) |-> ##3 fld_chr(char_o))
    else $error("streamed fourth char carries 01");
  a_stream_shape: assert property ($rose(char_valid_o) |-> five_chars)
    else $error("stream not five chars");
  a_stream_zeros: assert property ($rose(char_valid_o) |-> ##1 two_zeros)
    else $error("stream reserved chars not zero");
  a_stream_letter: assert property ($rose(char_valid_o) |-> char_o inside {8'h54, 8'h4C, 8'h4D, 8'h55})
    else $error("stream letter out of set");
endmodule
bind pse_encoder pse_chk u_pse_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .char_o(char_o),
  .char_valid_o(char_valid_o), .char_last_o(char_last_o), .code_o(code_o));

// file: bench/pse_host.sv
module pse_host (
  // Clock
  input wire logic        core_clk_i,
  // Stream from the encoder
  input wire logic [7:0]  char_i,
  input wire logic        char_valid_i,
  input wire logic        char_last_i,
  // Query and capture
  output logic            query_o,
  output logic [39:0]     got_o,
  output logic            done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    query_o = 1'b0;
    got_o = 40'h0;
    done_o = 1'b0;
  end
  // Letter arrives first, so it ends in the top byte
  always @(posedge core_clk_i) begin
    if (char_valid_i) got_o <= {got_o[31:0], char_i};
    done_o <= char_valid_i && char_last_i;
  end
  task ask();
    @(posedge core_clk_i);
    query_o <= 1'b1;
    @(posedge core_clk_i);
    query_o <= 1'b0;
  endtask
endmodule

// file: bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 0, nrst_i = 0, mute_i = 0, lock_i = 0, query_i, char_valid_o, char_last_o, done, irq;
  logic [1:0] audio_i = 0, encr_i = 0, signal_i = 0, conn_i = 0, bresp, rresp, r;
  logic [7:0] char_o, awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [39:0] code_o, got;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  int mismatches = 0, num_checks = 0, cyc = 0;
  initial forever #50 core_clk_i = ~core_clk_i;
  pse_encoder u_pse_encoder (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .mute_i(mute_i), .lock_i(lock_i),
    .audio_i(audio_i), .encr_i(encr_i), .signal_i(signal_i), .conn_i(conn_i), .query_i(query_i),
    .char_o(char_o), .char_valid_o(char_valid_o), .char_last_o(char_last_o), .code_o(code_o),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq_o(irq));
  pse_host u_pse_host (.core_clk_i(core_clk_i), .char_i(char_o), .char_valid_i(char_valid_o),
    .char_last_i(char_last_o), .query_o(query_i), .got_o(got), .done_o(done));
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Whole run needs well under 2000 cycles
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop;
    end
  end
  task chk(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction
  function automatic logic [39:0] expc(input logic [1:0] ml, input logic [7:0] b);
    logic [7:0] c;
    case (ml)
      2'h0: c = 8'h54;
      2'h1: c = 8'h4C;
      2'h2: c = 8'h4D;
      default: c = 8'h55;
    endcase
    return {c, 16'h3030, hx(b[7:4]), hx(b[3:0])};
  endfunction
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge core_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Pins pass a 3-flop synchroniser, so allow a fixed settling time
  task pins(input logic [1:0] ml, input logic [7:0] b);
    @(posedge core_clk_i);
    {mute_i, lock_i} <= ml;
    {audio_i, encr_i, signal_i, conn_i} <= b;
    repeat (8) @(posedge core_clk_i);
  endtask
  task stream(input logic [39:0] exp);
    u_pse_host.ask();
    for (int i = 0; i < 20 && !done; i++) @(posedge core_clk_i);
    chk(got, exp);
  endtask
  task s_pins;
    static logic [7:0] pats [4] = '{8'hAA, 8'hAF, 8'hEB, 8'h0F};
    for (int i = 0; i < 4; i++) begin
      pins(i[1:0], pats[i]);
      chk(code_o, expc(i[1:0], pats[i]));
      stream(expc(i[1:0], pats[i]));
    end
  endtask
  task s_rsvd;
    rd(8'h18);
    chk(d, 32'h0);
    pins(2'h0, 8'h79);
    chk(code_o, expc(2'h0, 8'h38));
    chk(irq, 1'b0);
    wr(8'h18, 32'h2);
    repeat (2) @(posedge core_clk_i);
    chk(irq, 1'b1);
    wr(8'h14, 32'h3);
    rd(8'h14);
    chk(d, 32'h2);
    pins(2'h0, 8'hAA);
    rd(8'h14);
    chk(d, 32'h3);
    wr(8'h14, 32'h3);
    repeat (2) @(posedge core_clk_i);
    chk(irq, 1'b0);
  endtask
  task s_regs;
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h3E2);
    repeat (3) @(posedge core_clk_i);
    rd(8'h0C);
    chk(d, 32'h45303055);
    rd(8'h10);
    chk(d[7:0], 8'h32);
    stream(expc(2'h3, 8'hE2));
    rd(8'h08);
    chk(d, 32'h3E2);
    wr(8'h04, 32'h1D5);
    repeat (2) @(posedge core_clk_i);
    chk(code_o, expc(2'h2, 8'hC0));
    rd(8'h08);
    chk(d, 32'h1C0);
    rd(8'h40);
    chk({r, d}, {2'h3, 32'h0});
    wr(8'h40, 32'h1);
    chk(r, 2'h3);
  endtask
  initial begin
    repeat (16) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    s_pins;
    s_rsvd;
    s_regs;
    report_and_stop;
  end
endmodule
